// *** bench/cod_chk.sv ***
// port assertions of the clock output divider
// assumes a bind onto cod_top
`timescale 1ns/1ps
`include "cod_regs.svh"
module cod_chk #(
    parameter int DIV_W = 5
) (
    input wire logic                   ref_clk,
    input wire logic                   rst_b,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`COD_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic                   pready,
    input wire logic [31:0]            prdata,
    input wire logic                   pslverr,
    input wire logic                   clk_out,
    input wire logic                   gpio4_clk,
    input wire logic                   gpio4_clk_oe,
    input wire logic                   gpio6_clk,
    input wire logic                   gpio6_clk_oe,
    input wire logic                   clk_idle
);
    wire acc = psel && penable;
    wire su  = paddr == `COD_SETUP_ADDR;
    wire po  = paddr == `COD_PORT_ADDR;
    wire clr = acc && pwrite && pstrb[0] && pwdata[7] && su;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    chk_gpio4_gate: assert property
        (gpio4_clk == (gpio4_clk_oe && clk_out)) else $error("gpio4 clock gate wrong");
    chk_gpio6_gate: assert property
        (gpio6_clk == (gpio6_clk_oe && clk_out)) else $error("gpio6 clock gate wrong");
    chk_clear_idle: assert property
        (clr |=> clk_idle) else $error("clear did not idle");
    chk_clear_level: assert property
        (clr |=> clk_out == $past(pwdata[6])) else $error("clear level wrong");
    chk_idle_read: assert property
        (psel && !penable && !pwrite && su |=> prdata[7] == $past(clk_idle))
        else $error("idle bit wrong");
    chk_run_toggle: assert property
        (!clk_idle |-> ##[1:32] ($changed(clk_out) || clk_idle)) else $error("no toggle");
    chk_stop_idle: assert property
        (acc && pwrite && pstrb[0] && po && !pwdata[3] |-> ##[1:33] clk_idle)
        else $error("disable never idles");
    chk_unmapped_err: assert property
        (acc |-> pslverr == !(su || po)) else $error("slave error wrong");
    chk_read_width: assert property
        (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
    cover property (clr);
    cover property (!clk_idle);
    cover property (acc && !(su || po));
endmodule // cod_chk

// *** bench/cod_clk_sink.sv ***
// receiving chip on a generated clock pin: measures low and high lengths
// assumes the line is sampled with the oscillator clock
`timescale 1ns/1ps
module cod_clk_sink (
    input wire logic ref_clk,
    input wire logic line,
    output int       lo_len,
    output int       hi_len
);
    int   cnt  = 0;
    logic last = 1'h0;
    always @(posedge ref_clk) begin
        if (line !== last) begin
            if (line)
                lo_len <= cnt;
            else
                hi_len <= cnt;
            cnt <= 1;
        end else
            cnt <= cnt + 1;
        last <= line;
    end
endmodule // cod_clk_sink

// *** bench/cod_tb.sv ***
// self-checking bench of the clock output divider
// assumes cod_top, cod_clk_sink and cod_chk compiled first
`timescale 1ns/1ps
`include "cod_regs.svh"
module tb;
    logic        ref_clk = 1'h0;
    logic        rst_b   = 1'h0;
    logic        psel    = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite  = 1'h0;
    logic [11:0] paddr   = 12'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'hF;
    logic [31:0] prdata, rd, seed = 32'h4370;
    logic        pready, pslverr, clk_out, g4, g4_oe, g6, g6_oe, clk_idle, er;
    int          errors = 0, num_checks = 0, lo, hi;
    int          nq[$] = '{3, 31, 2};
    time         t0, t1;
    always #2 ref_clk = ~ref_clk;
    cod_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .clk_out(clk_out), .gpio4_clk(g4),
        .gpio4_clk_oe(g4_oe), .gpio6_clk(g6), .gpio6_clk_oe(g6_oe), .clk_idle(clk_idle));
    cod_clk_sink sink (.ref_clk(ref_clk), .line(g4), .lo_len(lo), .hi_len(hi));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'h1;
        apb(1'h0, `COD_SETUP_ADDR, 32'h0);
        chk("setup", rd, 32'h80);
        apb(1'h0, `COD_PORT_ADDR, 32'h0);
        chk("port", rd, 32'h0);
        apb(1'h0, 12'h0, 32'h0);
        chk("slverr", {31'h0, er}, 32'h1);
        // settings first, then enable
        apb(1'h1, `COD_SETUP_ADDR, 32'h3);
        apb(1'h1, `COD_PORT_ADDR, 32'h38);
        apb(1'h0, `COD_PORT_ADDR, 32'h0);
        chk("port", rd, 32'h38);
        repeat (4) nq.push_back(2 + xs() % 30);
        foreach (nq[i]) begin
            apb(1'h1, `COD_SETUP_ADDR, 32'h80 | nq[i]);
            repeat (3 * nq[i] + 4) @(posedge ref_clk);
            chk("low", lo, nq[i] / 2);
            chk("high", hi, nq[i] - nq[i] / 2);
            apb(1'h0, `COD_SETUP_ADDR, 32'h0);
            chk("run", rd, nq[i]);
        end
        apb(1'h1, `COD_PORT_ADDR, 32'h30);
        repeat (33) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("idle", clk_idle, 1'h1);
        chk("stop", clk_out, 1'h0);
        apb(1'h1, `COD_SETUP_ADDR, 32'h45);
        @(negedge ref_clk);
        chk("inv", clk_out, 1'h1);
        apb(1'h1, `COD_SETUP_ADDR, 32'h1);
        apb(1'h1, `COD_PORT_ADDR, 32'h38);
        apb(1'h0, `COD_SETUP_ADDR, 32'h0);
        chk("pass", rd, 32'h81);
        apb(1'h1, `COD_SETUP_ADDR, 32'hA3);
        repeat (8) @(posedge ref_clk);
        @(posedge clk_out) t0 = $time;
        @(negedge clk_out) t1 = $time;
        @(posedge clk_out);
        chk("bal_hi", 32'(t1 - t0), 32'h6);
        chk("bal_lo", 32'($time - t1), 32'h6);
        finish_test();
    end
endmodule // tb
bind cod_top cod_chk #(.DIV_W(DIV_W)) u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .clk_out(clk_out),
    .gpio4_clk(gpio4_clk), .gpio4_clk_oe(gpio4_clk_oe), .gpio6_clk(gpio6_clk),
    .gpio6_clk_oe(gpio6_clk_oe), .clk_idle(clk_idle));

// *** src/cod_out_stage.sv ***
// output shaping of the clock output divider: half-cycle balance, bypass, inversion
// assumes ref_clk is the oscillator and raw_q comes from a ref_clk flop
`timescale 1ns/1ps

module cod_out_stage
    import cod_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic raw_q,
    input  wire logic balance_on,
    input  wire logic pass_on,
    input  wire logic invert,
    output logic      clk_out
);

    logic neg_q;
    wire  logic shaped;
    wire  logic base;

    always_ff @(negedge ref_clk) begin
        if (!rst_b) begin
            neg_q <= 1'b0;
        end else begin
            neg_q <= raw_q;
        end
    end

    assign shaped  = balance_on ? (raw_q & neg_q) : raw_q;
    assign base    = pass_on ? ref_clk : shaped;
    assign clk_out = base ^ invert;

endmodule // cod_out_stage

// *** src/cod_pkg.sv ***
// types shared by the clock output divider files
// assumes cod_regs.svh on the include path
`include "cod_regs.svh"

package cod_pkg;

    typedef struct packed {
        logic                    output_invert;
        logic                    duty_balance;
        logic [`COD_DIV_W-1:0]   div;
    } cod_setup_t;

    typedef struct packed {
        logic [1:0] pin_sel;
        logic       enable;
    } cod_port_t;

    typedef enum logic [2:0] {
        COD_ST_IDLE = 3'b001,
        COD_ST_RUN  = 3'b010,
        COD_ST_PASS = 3'b100
    } cod_state_t;

endpackage

// *** src/cod_regs.svh ***
// register indices, byte addresses, field positions and reset values
// of the clock output divider; included by the package and the design
`ifndef COD_REGS_SVH
`define COD_REGS_SVH

`define COD_ADDR_W          12
`define COD_SETUP_IDX       8'h8F
`define COD_PORT_IDX        8'hB6
`define COD_SETUP_ADDR      {2'b00, `COD_SETUP_IDX, 2'b00}
`define COD_PORT_ADDR       {2'b00, `COD_PORT_IDX, 2'b00}

`define COD_SETUP_CLR_BIT   7
`define COD_SETUP_INV_BIT   6
`define COD_SETUP_BAL_BIT   5
`define COD_SETUP_DIV_MSB   4
`define COD_SETUP_DIV_LSB   0
`define COD_PORT_SEL_MSB    5
`define COD_PORT_SEL_LSB    4
`define COD_PORT_EN_BIT     3

`define COD_SETUP_RST       8'h00
`define COD_PORT_RST        8'h00
`define COD_DIV_W           5
`define COD_DIV_MIN_RUN     5'h02

`endif

// *** src/cod_top.sv ***
// clock output divider: apb registers, period counter and pin routing
// assumes ref_clk is the oscillator feeding the divider and a synchronous apb master
//
// Overview of operation
// - output derives from oscillator, not system divider
// - division ratios one through thirty-one
// - factor bits 4:0; zero/one pass oscillator
// - new factor adopted after current period
// - writing clear bit resets divider, output at inversion bit level
// - clear bit reads idle status
// - inversion bit 6 is last stage
// - inversion change applies immediately, runt possible
// - balance bit 5 gives near 1:1 duty
// - setup register resets to zero
// - two pin selects, enable gates waveform only
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

`include "cod_regs.svh"

module cod_top
    import cod_pkg::*;
#(
    parameter int DIV_W = `COD_DIV_W
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`COD_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    output logic                        clk_out,
    output logic                        gpio4_clk,
    output logic                        gpio4_clk_oe,
    output logic                        gpio6_clk,
    output logic                        gpio6_clk_oe,
    output logic                        clk_idle
);

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    cod_setup_t            setup_q;
    cod_port_t             port_q;
    logic [31:0]           prdata_q;
    cod_state_t            state_q;
    cod_state_t            state_d;
    logic [DIV_W-1:0]      cnt_q;
    logic [DIV_W-1:0]      cnt_d;
    logic [DIV_W-1:0]      act_q;
    logic [DIV_W-1:0]      act_d;
    logic                  raw_q;

    wire logic             sel_setup  = (paddr == `COD_SETUP_ADDR);
    wire logic             sel_port   = (paddr == `COD_PORT_ADDR);
    wire logic             mapped     = sel_setup | sel_port;
    wire logic             access     = psel & penable;
    wire logic             wr_lane0   = access & pwrite & mapped & pstrb[0];
    wire logic             wr_setup   = wr_lane0 & sel_setup;
    wire logic             wr_port    = wr_lane0 & sel_port;
    wire logic             rd_setup   = psel & ~penable & ~pwrite & sel_setup;
    wire logic             rd_port    = psel & ~penable & ~pwrite & sel_port;
    wire logic             clear_pls  = wr_setup & pwdata[`COD_SETUP_CLR_BIT];
    wire logic [DIV_W-1:0] wr_div     = pwdata[`COD_SETUP_DIV_MSB:`COD_SETUP_DIV_LSB];
    wire logic             enable     = port_q.enable;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_q;

    function automatic logic div_runs(input logic [DIV_W-1:0] d);
        div_runs = (d >= `COD_DIV_MIN_RUN);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            setup_q <= cod_setup_t'(`COD_SETUP_RST);
            port_q  <= cod_port_t'(3'h0);
        end else begin
            if (wr_setup) begin
                setup_q.output_invert <= pwdata[`COD_SETUP_INV_BIT];
                setup_q.duty_balance  <= pwdata[`COD_SETUP_BAL_BIT];
                setup_q.div           <= wr_div;
            end
            if (wr_port) begin
                port_q.pin_sel <= pwdata[`COD_PORT_SEL_MSB:`COD_PORT_SEL_LSB];
                port_q.enable  <= pwdata[`COD_PORT_EN_BIT];
            end
        end
    end

    wire logic [7:0] setup_rd = {clk_idle, setup_q.output_invert, setup_q.duty_balance,
                                 setup_q.div};
    wire logic [7:0] port_rd  = {2'b00, port_q.pin_sel, port_q.enable, 3'b000};

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= {24'h00_0000, setup_rd};
        end else if (rd_port) begin
            prdata_q <= {24'h00_0000, port_rd};
        end else if (psel & ~penable) begin
            prdata_q <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // period counter

    wire logic [DIV_W-1:0] half     = act_q >> 1;
    wire logic             last_cyc = (cnt_q == act_q - {{(DIV_W-1){1'b0}}, 1'b1});

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        act_d   = act_q;
        case (state_q)
            COD_ST_IDLE: begin
                if (enable) begin
                    act_d   = setup_q.div;
                    cnt_d   = '0;
                    state_d = div_runs(setup_q.div) ? COD_ST_RUN : COD_ST_PASS;
                end
            end
            COD_ST_RUN: begin
                if (last_cyc) begin
                    cnt_d = '0;
                    if (!enable) begin
                        state_d = COD_ST_IDLE;
                    end else begin
                        act_d   = setup_q.div;
                        state_d = div_runs(setup_q.div) ? COD_ST_RUN : COD_ST_PASS;
                    end
                end else begin
                    cnt_d = cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
                end
            end
            COD_ST_PASS: begin
                act_d = setup_q.div;
                if (!enable) begin
                    state_d = COD_ST_IDLE;
                end else if (div_runs(setup_q.div)) begin
                    cnt_d   = '0;
                    state_d = COD_ST_RUN;
                end
            end
            default: begin
                state_d = COD_ST_IDLE;
                cnt_d   = '0;
            end
        endcase
        if (clear_pls) begin
            state_d = COD_ST_IDLE;
            cnt_d   = '0;
            act_d   = wr_div;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q <= COD_ST_IDLE;
            cnt_q   <= '0;
            act_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            act_q   <= act_d;
        end
    end

    wire logic [DIV_W-1:0] half_d = act_d >> 1;
    wire logic             raw_d  = (state_d == COD_ST_RUN) & (cnt_d >= half_d);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            raw_q <= 1'b0;
        end else begin
            raw_q <= raw_d;
        end
    end

    assign clk_idle = (state_q != COD_ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // output stage and pins

    wire logic balance_on = setup_q.duty_balance & act_q[0] & (state_q == COD_ST_RUN);
    wire logic pass_on    = (state_q == COD_ST_PASS);
    wire logic unused_hi  = |{pwdata[31:8], pstrb[3:1], half};

    cod_out_stage u_out_stage (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .raw_q      (raw_q),
        .balance_on (balance_on),
        .pass_on    (pass_on),
        .invert     (setup_q.output_invert),
        .clk_out    (clk_out)
    );

    assign gpio4_clk    = port_q.pin_sel[0] & clk_out;
    assign gpio4_clk_oe = port_q.pin_sel[0];
    assign gpio6_clk    = port_q.pin_sel[1] & clk_out;
    assign gpio6_clk_oe = port_q.pin_sel[1];

endmodule // cod_top
